/* core/coc_top.sv */
// Comparator output control: three lockable control registers on APB and
// output conditioning with blanking and routing to timer inputs.
// Assumes raw comparator outputs and timer compare windows arrive asynchronously.
`timescale 1ns/1ps
module coc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_two_raw,
    input wire logic cmp_four_raw,
    input wire logic cmp_six_raw,
    input wire logic t1_oc5,
    input wire logic t2_oc3,
    input wire logic t2_oc4,
    input wire logic t15_oc1,
    input wire logic t15_oc2,
    output logic cmp_two_on,
    output logic cmp_four_on,
    output logic cmp_six_on,
    output logic [2:0] cmp_two_minus_source,
    output logic [2:0] cmp_four_minus_source,
    output logic [2:0] cmp_six_minus_source,
    output logic cmp_two_plus_dac_switch,
    output logic timer_stop_input_high,
    output logic timer_stop_input_second,
    output logic t1_ref_clear,
    output logic t1_capture1,
    output logic t2_capture4,
    output logic t2_capture2,
    output logic t2_ref_clear,
    output logic t15_capture2,
    output logic t15_ref_clear,
    output logic t16_ref_clear,
    output logic t16_capture1
);
    import coc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: every asynchronous level passes two flip-flops.
    logic sy_two;
    logic sy_four;
    logic sy_six;
    logic sy_t1_oc5;
    logic sy_t2_oc3;
    logic sy_t2_oc4;
    logic sy_t15_oc1;
    logic sy_t15_oc2;

    coc_sync u_sync_two (
        .pclk(pclk),
        .presetn(presetn),
        .d(cmp_two_raw),
        .q(sy_two)
    );

    coc_sync u_sync_four (
        .pclk(pclk),
        .presetn(presetn),
        .d(cmp_four_raw),
        .q(sy_four)
    );

    coc_sync u_sync_six (
        .pclk(pclk),
        .presetn(presetn),
        .d(cmp_six_raw),
        .q(sy_six)
    );

    coc_sync u_sync_t1_oc5 (
        .pclk(pclk),
        .presetn(presetn),
        .d(t1_oc5),
        .q(sy_t1_oc5)
    );

    coc_sync u_sync_t2_oc3 (
        .pclk(pclk),
        .presetn(presetn),
        .d(t2_oc3),
        .q(sy_t2_oc3)
    );

    coc_sync u_sync_t2_oc4 (
        .pclk(pclk),
        .presetn(presetn),
        .d(t2_oc4),
        .q(sy_t2_oc4)
    );

    coc_sync u_sync_t15_oc1 (
        .pclk(pclk),
        .presetn(presetn),
        .d(t15_oc1),
        .q(sy_t15_oc1)
    );

    coc_sync u_sync_t15_oc2 (
        .pclk(pclk),
        .presetn(presetn),
        .d(t15_oc2),
        .q(sy_t15_oc2)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode and registers.
    logic wr_access;
    logic hit_two;
    logic hit_four;
    logic hit_six;
    logic hit_any;
    logic wr_two;
    logic wr_four;
    logic wr_six;
    logic rd_setup;
    logic [31:0] csr_two;
    logic [31:0] csr_four;
    logic [31:0] csr_six;

    assign wr_access = psel && penable && pwrite;
    assign hit_two = (paddr == COC_OFF_CMP_TWO);
    assign hit_four = (paddr == COC_OFF_CMP_FOUR);
    assign hit_six = (paddr == COC_OFF_CMP_SIX);
    assign hit_any = hit_two || hit_four || hit_six;
    assign wr_two = wr_access && hit_two;
    assign wr_four = wr_access && hit_four;
    assign wr_six = wr_access && hit_six;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    coc_csr #(.WMASK(COC_WMASK_TWO)) u_csr_two (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_two),
        .wdata(pwdata),
        .pstrb(pstrb),
        .csr(csr_two)
    );
    coc_csr #(.WMASK(COC_WMASK_OTHER)) u_csr_four (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_four),
        .wdata(pwdata),
        .pstrb(pstrb),
        .csr(csr_four)
    );
    coc_csr #(.WMASK(COC_WMASK_OTHER)) u_csr_six (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_six),
        .wdata(pwdata),
        .pstrb(pstrb),
        .csr(csr_six)
    );

    ////////////////////////////////////////////////////////////////////////
    // Field extraction.
    logic [2:0] mask_two;
    logic [2:0] mask_four;
    logic [2:0] mask_six;
    logic [3:0] route_two;
    logic [3:0] route_four;
    logic [3:0] route_six;
    logic inv_two;
    logic inv_four;
    logic inv_six;

    assign mask_two = csr_two[COC_MASK_HI:COC_MASK_LO];
    assign mask_four = csr_four[COC_MASK_HI:COC_MASK_LO];
    assign mask_six = csr_six[COC_MASK_HI:COC_MASK_LO];
    assign route_two = csr_two[COC_ROUTE_HI:COC_ROUTE_LO];
    assign route_four = csr_four[COC_ROUTE_HI:COC_ROUTE_LO];
    assign route_six = csr_six[COC_ROUTE_HI:COC_ROUTE_LO];
    assign cmp_two_on = csr_two[COC_BIT_ON];
    assign cmp_four_on = csr_four[COC_BIT_ON];
    assign cmp_six_on = csr_six[COC_BIT_ON];
    assign cmp_two_minus_source = csr_two[COC_MINUS_HI:COC_MINUS_LO];
    assign cmp_four_minus_source = csr_four[COC_MINUS_HI:COC_MINUS_LO];
    assign cmp_six_minus_source = csr_six[COC_MINUS_HI:COC_MINUS_LO];
    assign cmp_two_plus_dac_switch = csr_two[COC_BIT_DAC_SW];
    assign inv_two = csr_two[COC_BIT_INVERT];
    assign inv_four = csr_four[COC_BIT_INVERT];
    assign inv_six = csr_six[COC_BIT_INVERT];

    ////////////////////////////////////////////////////////////////////////
    // Blanking source selection; reserved codes give no blanking.
    logic blank_two;
    logic blank_four;
    logic blank_six;

    assign blank_two = (mask_two == COC_MASK_SRC_1) ? sy_t1_oc5 :
                       (mask_two == COC_MASK_SRC_2) ? sy_t2_oc3 : 1'b0;
    assign blank_four = (mask_four == COC_MASK_SRC_3) ? sy_t15_oc1 : 1'b0;
    assign blank_six = (mask_six == COC_MASK_SRC_3) ? sy_t2_oc4 :
                       (mask_six == COC_MASK_SRC_4) ? sy_t15_oc2 : 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Status, polarity and blanking.
    logic state_two;
    logic state_four;
    logic state_six;
    logic pol_two;
    logic pol_four;
    logic pol_six;
    logic cond_two;
    logic cond_four;
    logic cond_six;

    assign state_two = sy_two && cmp_two_on;
    assign state_four = sy_four && cmp_four_on;
    assign state_six = sy_six && cmp_six_on;
    assign pol_two = sy_two ^ inv_two;
    assign pol_four = sy_four ^ inv_four;
    assign pol_six = sy_six ^ inv_six;
    assign cond_two = cmp_two_on && pol_two && !blank_two;
    assign cond_four = cmp_four_on && pol_four && !blank_four;
    assign cond_six = cmp_six_on && pol_six && !blank_six;

    ////////////////////////////////////////////////////////////////////////
    // Routing to timer inputs, registered; unselected inputs stay low.
    logic two_stop_hi;
    logic two_stop_2;
    logic two_t1_clr;
    logic two_t1_cap1;
    logic two_t2_cap4;
    logic two_t2_clr;
    logic four_stop_hi;
    logic four_stop_2;
    logic four_t15_cap2;
    logic four_t15_clr;
    logic six_stop_hi;
    logic six_stop_2;
    logic six_t2_cap2;
    logic six_t2_clr;
    logic six_t16_clr;
    logic six_t16_cap1;
    logic [10:0] rt_vec;
    logic [10:0] rt_ff;

    assign two_stop_hi = cond_two && route_two == COC_RT_STOP_HIGH;
    assign two_stop_2 = cond_two && (route_two == COC_RT_STOP_SECOND ||
                                     route_two == COC_RT_STOP_SECOND_B);
    assign two_t1_clr = cond_two && route_two == COC_RT_6;
    assign two_t1_cap1 = cond_two && route_two == COC_RT_7;
    assign two_t2_cap4 = cond_two && route_two == COC_RT_8;
    assign two_t2_clr = cond_two && route_two == COC_RT_9;

    assign four_stop_hi = cond_four && route_four == COC_RT_STOP_HIGH;
    assign four_stop_2 = cond_four && (route_four == COC_RT_STOP_SECOND ||
                                       route_four == COC_RT_STOP_SECOND_B);
    assign four_t15_cap2 = cond_four && route_four == COC_RT_8;
    assign four_t15_clr = cond_four && route_four == COC_RT_A;

    assign six_stop_hi = cond_six && route_six == COC_RT_STOP_HIGH;
    assign six_stop_2 = cond_six && (route_six == COC_RT_STOP_SECOND ||
                                     route_six == COC_RT_STOP_SECOND_B);
    assign six_t2_cap2 = cond_six && route_six == COC_RT_6;
    assign six_t2_clr = cond_six && route_six == COC_RT_8;
    assign six_t16_clr = cond_six && route_six == COC_RT_9;
    assign six_t16_cap1 = cond_six && route_six == COC_RT_A;

    assign rt_vec = {
        six_t16_cap1,
        six_t16_clr,
        four_t15_clr,
        four_t15_cap2,
        two_t2_clr || six_t2_clr,
        six_t2_cap2,
        two_t2_cap4,
        two_t1_cap1,
        two_t1_clr,
        two_stop_2 || four_stop_2 || six_stop_2,
        two_stop_hi || four_stop_hi || six_stop_hi
    };

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rt_ff <= '0;
        end else begin
            rt_ff <= rt_vec;
        end
    end
    assign timer_stop_input_high = rt_ff[0];
    assign timer_stop_input_second = rt_ff[1];
    assign t1_ref_clear = rt_ff[2];
    assign t1_capture1 = rt_ff[3];
    assign t2_capture4 = rt_ff[4];
    assign t2_capture2 = rt_ff[5];
    assign t2_ref_clear = rt_ff[6];
    assign t15_capture2 = rt_ff[7];
    assign t15_ref_clear = rt_ff[8];
    assign t16_ref_clear = rt_ff[9];
    assign t16_capture1 = rt_ff[10];

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered during the setup phase.
    logic [31:0] rd_two;
    logic [31:0] rd_four;
    logic [31:0] rd_six;
    logic [31:0] rd_mux;
    logic [31:0] prdata_ff;

    assign rd_two = {csr_two[31], state_two, csr_two[29:0]};
    assign rd_four = {csr_four[31], state_four, csr_four[29:0]};
    assign rd_six = {csr_six[31], state_six, csr_six[29:0]};
    assign rd_mux = hit_two ? rd_two :
                    hit_four ? rd_four :
                    hit_six ? rd_six :
                    32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_ff <= rd_mux;
        end
    end
    assign prdata = prdata_ff;
endmodule

/* inc/coc_pkg.sv */
// Constants for the comparator output control block.
// Assumes a 32-bit APB register bus and a 100 MHz pclk.
package coc_pkg;
    localparam logic [11:0] COC_OFF_CMP_TWO = 12'h020;
    localparam logic [11:0] COC_OFF_CMP_FOUR = 12'h028;
    localparam logic [11:0] COC_OFF_CMP_SIX = 12'h030;
    localparam logic [31:0] COC_CSR_RESET = 32'h00000000;
    localparam int COC_BIT_LOCK = 31;
    localparam int COC_BIT_STATE = 30;
    localparam int COC_MASK_HI = 20;
    localparam int COC_MASK_LO = 18;
    localparam int COC_BIT_INVERT = 15;
    localparam int COC_ROUTE_HI = 13;
    localparam int COC_ROUTE_LO = 10;
    localparam int COC_MINUS_HI = 6;
    localparam int COC_MINUS_LO = 4;
    localparam int COC_BIT_DAC_SW = 1;
    localparam int COC_BIT_ON = 0;
    // Writable field masks per comparator.
    localparam logic [31:0] COC_WMASK_TWO = 32'h801CBC73;
    localparam logic [31:0] COC_WMASK_OTHER = 32'h801CBC71;
    // Blanking source codes.
    localparam logic [2:0] COC_MASK_NONE = 3'h0;
    localparam logic [2:0] COC_MASK_SRC_1 = 3'h1;
    localparam logic [2:0] COC_MASK_SRC_2 = 3'h2;
    localparam logic [2:0] COC_MASK_SRC_3 = 3'h3;
    localparam logic [2:0] COC_MASK_SRC_4 = 3'h4;
    // Inverting input codes.
    localparam logic [2:0] COC_MINUS_QUARTER = 3'h0;
    localparam logic [2:0] COC_MINUS_HALF = 3'h1;
    localparam logic [2:0] COC_MINUS_3QUARTER = 3'h2;
    localparam logic [2:0] COC_MINUS_FULL = 3'h3;
    localparam logic [2:0] COC_MINUS_DAC = 3'h4;
    localparam logic [2:0] COC_MINUS_PIN_TWO = 3'h6;
    localparam logic [2:0] COC_MINUS_PIN_OTHER = 3'h7;
    // Output route codes.
    localparam logic [3:0] COC_RT_NONE = 4'h0;
    localparam logic [3:0] COC_RT_STOP_HIGH = 4'h1;
    localparam logic [3:0] COC_RT_STOP_SECOND = 4'h2;
    localparam logic [3:0] COC_RT_STOP_SECOND_B = 4'h5;
    localparam logic [3:0] COC_RT_6 = 4'h6;
    localparam logic [3:0] COC_RT_7 = 4'h7;
    localparam logic [3:0] COC_RT_8 = 4'h8;
    localparam logic [3:0] COC_RT_9 = 4'h9;
    localparam logic [3:0] COC_RT_A = 4'hA;
endpackage

/* core/coc_sync.sv */
// Two flip-flop synchroniser for one level.
// Assumes pclk and the active-low asynchronous reset presetn.
`timescale 1ns/1ps
module coc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d,
    output logic q
);
    logic meta_ff;
    logic q_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule

/* core/coc_csr.sv */
// One lockable comparator control and status register.
// Assumes write strobes from the APB decoder on the same clock.
`timescale 1ns/1ps
module coc_csr #(
    parameter logic [31:0] WMASK = 32'h801CBC71
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] csr
);
    import coc_pkg::*;
    logic [31:0] csr_ff;
    logic [31:0] lane_mask;
    logic [31:0] nxt_csr;
    logic locked;
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign locked = csr_ff[COC_BIT_LOCK];
    assign nxt_csr = (csr_ff & ~(lane_mask & WMASK)) | (wdata & lane_mask & WMASK);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr_ff <= COC_CSR_RESET;
        end else if (wr_en && !locked) begin
            csr_ff <= nxt_csr;
        end
    end
    assign csr = csr_ff;
endmodule

/* tb/coc_timer_model.sv */
// Timer side model: drives the compare windows used for blanking.
// Assumes the bench requests windows on pclk.
`timescale 1ns/1ps
module coc_timer_model (
    input wire logic pclk,
    input wire logic [4:0] win,
    output logic t1_oc5,
    output logic t2_oc3,
    output logic t2_oc4,
    output logic t15_oc1,
    output logic t15_oc2
);
    logic [4:0] oc_ff = 5'h00;
    // Windows are active high and change only on the clock.
    always @(posedge pclk) begin
        oc_ff <= win;
    end
    assign {t15_oc2, t15_oc1, t2_oc4, t2_oc3, t1_oc5} = oc_ff;
endmodule

/* tb/coc_top_chk.sv */
// Checker for the comparator output control block.
// Assumes it is bound to coc_top and sees only its ports.
`timescale 1ns/1ps
module coc_top_chk
    import coc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic cmp_two_on,
    input wire logic [2:0] cmp_two_minus_source,
    input wire logic cmp_two_plus_dac_switch,
    input wire logic cmp_four_on,
    input wire logic t1_ref_clear,
    input wire logic t1_capture1,
    input wire logic t2_capture4,
    input wire logic t15_capture2,
    input wire logic t15_ref_clear,
    input wire logic t16_ref_clear,
    input wire logic t16_capture1
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic lk2_ff;
    wire logic wr2;
    assign wr2 = psel && penable && pwrite && pready && paddr == COC_OFF_CMP_TWO && !lk2_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lk2_ff <= 1'b0;
        else if (wr2 && pstrb[3] && pwdata[31])
            lk2_ff <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_on;
        wr2 && pstrb[0] |=> cmp_two_on == $past(pwdata[0]);
    endproperty
    a_on: assert property (p_on) else $error("enable not applied");
    property p_minus;
        wr2 && pstrb[0] |=> cmp_two_minus_source == $past(pwdata[6:4]);
    endproperty
    a_minus: assert property (p_minus) else $error("minus source wrong");
    property p_dac;
        wr2 && pstrb[0] |=> cmp_two_plus_dac_switch == $past(pwdata[1]);
    endproperty
    a_dac: assert property (p_dac) else $error("dac switch wrong");
    property p_hold;
        lk2_ff |=> $stable(cmp_two_on) && $stable(cmp_two_minus_source)
            && $stable(cmp_two_plus_dac_switch);
    endproperty
    a_hold: assert property (p_hold) else $error("locked register changed");
    property p_off2;
        !cmp_two_on [*4] |-> !t1_ref_clear && !t1_capture1 && !t2_capture4;
    endproperty
    a_off2: assert property (p_off2) else $error("disabled output high");
    property p_off4;
        !cmp_four_on [*4] |-> !t15_capture2 && !t15_ref_clear;
    endproperty
    a_off4: assert property (p_off4) else $error("disabled output high");
    property p_one2;
        $onehot0({t1_ref_clear, t1_capture1, t2_capture4});
    endproperty
    a_one2: assert property (p_one2) else $error("two routes at once");
    property p_one4;
        !(t15_capture2 && t15_ref_clear);
    endproperty
    a_one4: assert property (p_one4) else $error("two routes at once");
    property p_one6;
        !(t16_ref_clear && t16_capture1);
    endproperty
    a_one6: assert property (p_one6) else $error("two routes at once");
endmodule
bind coc_top coc_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr,
    .pwdata, .pstrb, .cmp_two_on, .cmp_two_minus_source, .cmp_two_plus_dac_switch,
    .cmp_four_on, .t1_ref_clear, .t1_capture1, .t2_capture4, .t15_capture2, .t15_ref_clear,
    .t16_ref_clear, .t16_capture1);

/* tb/tb_comparator_output_control.sv */
// Testbench for the comparator output control block.
// Assumes coc_top, the timer model and the bound checker.
`timescale 1ns/1ps
module tb_comparator_output_control;
    import coc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = '0, e;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [3:0] pstrb = '0;
    logic [2:0] raw = '0, m2, m4, m6;
    logic [4:0] win = '0;
    logic [10:0] rt;
    logic c2on, c4on, c6on, dacsw, t1_oc5, t2_oc3, t2_oc4, t15_oc1, t15_oc2;
    int n_errors = 0, compares = 0;
    logic [11:0] adr [3] = '{COC_OFF_CMP_TWO, COC_OFF_CMP_FOUR, COC_OFF_CMP_SIX};
    logic [11:0] rtab [19] = '{12'h01A, 12'h029, 12'h059, 12'h068, 12'h077, 12'h086,
        12'h094, 12'h11A, 12'h129, 12'h159, 12'h183, 12'h1A2, 12'h21A, 12'h229, 12'h259,
        12'h265, 12'h284, 12'h291, 12'h2A0};
    logic [11:0] btab [5] = '{12'h010, 12'h021, 12'h133, 12'h232, 12'h244};
    coc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .cmp_two_raw(raw[0]), .cmp_four_raw(raw[1]),
        .cmp_six_raw(raw[2]), .t1_oc5, .t2_oc3, .t2_oc4, .t15_oc1, .t15_oc2,
        .cmp_two_on(c2on), .cmp_four_on(c4on), .cmp_six_on(c6on),
        .cmp_two_minus_source(m2), .cmp_four_minus_source(m4), .cmp_six_minus_source(m6),
        .cmp_two_plus_dac_switch(dacsw), .timer_stop_input_high(rt[10]),
        .timer_stop_input_second(rt[9]), .t1_ref_clear(rt[8]), .t1_capture1(rt[7]),
        .t2_capture4(rt[6]), .t2_capture2(rt[5]), .t2_ref_clear(rt[4]),
        .t15_capture2(rt[3]), .t15_ref_clear(rt[2]), .t16_ref_clear(rt[1]),
        .t16_capture1(rt[0]));
    coc_timer_model u_tmr (.pclk, .win, .t1_oc5, .t2_oc3, .t2_oc4, .t15_oc1, .t15_oc2);
    initial begin
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic close_out;
        $display("compares=%0d errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        close_out;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (adr[i]) begin
            xfer(0, adr[i], 0);
            chk(rdat, COC_CSR_RESET);
        end
        $display("reset values done");
        foreach (adr[i]) begin
            xfer(1, adr[i], {25'h0, (i == 0) ? 3'h6 : 3'h7, 4'h2});
            xfer(0, adr[i], 0);
            chk(rdat, (i == 0) ? 32'h62 : 32'h70);
        end
        chk({m6, m4, m2, dacsw}, {3'h7, 3'h7, 3'h6, 1'b1});
        $display("input select done");
        foreach (rtab[k]) begin
            e = rtab[k];
            raw <= 3'h1 << e[9:8];
            xfer(1, adr[e[9:8]], {18'h0, e[7:4], 10'h1});
            repeat (4) @(posedge pclk);
            chk({c6on, c4on, c2on, rt}, {3'h1 << e[9:8], 11'h1 << e[3:0]});
            xfer(0, adr[e[9:8]], 0);
            chk(rdat, {2'b01, 16'h0, e[7:4], 10'h1});
            xfer(1, adr[e[9:8]], {18'h0, e[7:4], 10'h0});
            repeat (4) @(posedge pclk);
            chk(rt, 0);
        end
        $display("routing done");
        foreach (btab[k]) begin
            e = btab[k];
            raw <= 3'h0;
            win <= ~(5'h1 << e[3:0]);
            xfer(1, adr[e[9:8]], {11'h0, e[6:4], 2'b0, 1'b1, 1'b0, 4'h1, 10'h1});
            repeat (5) @(posedge pclk);
            chk(rt[10], 1'b1);
            win <= 5'h1 << e[3:0];
            repeat (5) @(posedge pclk);
            chk(rt[10], 1'b0);
            win <= 5'h00;
            xfer(1, adr[e[9:8]], 0);
        end
        $display("blanking done");
        xfer(0, 12'h024, 0);
        chk(err, 1'b1);
        chk(rdat, 0);
        xfer(1, COC_OFF_CMP_TWO, 32'h80000001);
        xfer(1, COC_OFF_CMP_TWO, 32'h00000060);
        xfer(0, COC_OFF_CMP_TWO, 0);
        chk(rdat, 32'h80000001);
        chk(c2on, 1'b1);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1, COC_OFF_CMP_TWO, 32'h00000001);
        xfer(0, COC_OFF_CMP_TWO, 0);
        chk(rdat, 32'h00000001);
        $display("lock done");
        close_out;
    end
endmodule
